// ---- rtl/orpea_ram_ctrl.sv ----
`timescale 1ns/1ns
// on-chip ram access: ecc area, two parity banks and a zero-wait bank
module orpea_ram_ctrl #(
	parameter int ECC_DEPTH  = orpea_pkg::ECC_WORDS,
	parameter int ZERO_DEPTH = orpea_pkg::ZERO_WORDS,
	parameter int ONE_DEPTH  = orpea_pkg::ONE_WORDS,
	parameter int HS_DEPTH   = orpea_pkg::HS_WORDS
) (
	input  wire logic                ref_clk,
	input  wire logic                rstn,
	input  wire orpea_pkg::orpea_req_t busReq,
	output logic                     busReady,
	output orpea_pkg::orpea_rsp_t    busRsp,
	input  wire logic                zeroWaitSel,
	input  wire logic                moduleStop,
	input  wire logic                deepStandby,
	output logic                     errEvent
);
	import orpea_pkg::*;

	localparam int ECC_IW  = $clog2(ECC_DEPTH);
	localparam int ZERO_IW = $clog2(ZERO_DEPTH);
	localparam int ONE_IW  = $clog2(ONE_DEPTH);
	localparam int HS_IW   = $clog2(HS_DEPTH);

	// ****************************************************************
	// storage
	// ****************************************************************
	// ecc words carry no parity bits
	logic [DATA_W+ECC_W-1:0] ramEcc  [ECC_DEPTH];
	logic [DATA_W+LANES-1:0] ramZero [ZERO_DEPTH];
	logic [DATA_W+LANES-1:0] ramOne  [ONE_DEPTH];
	logic [DATA_W+LANES-1:0] ramHs   [HS_DEPTH];

	logic [DATA_W+ECC_W-1:0] rdEcc;
	logic [DATA_W+LANES-1:0] rdZero;
	logic [DATA_W+LANES-1:0] rdOne;
	logic [DATA_W+LANES-1:0] rdHs;

	orpea_ctl_t              r;
	orpea_ctl_t              next_r;

	orpea_bank_t             decBank;
	orpea_bank_t             bankSel;
	logic [31:0]             addrSel;
	logic [31:0]             offEcc;
	logic [31:0]             offZero;
	logic [31:0]             offOne;
	logic [31:0]             offHs;
	logic                    memRe;
	logic                    memWe;
	logic [3:0]              memBe;
	logic [DATA_W-1:0]       wrData;
	logic [LANES-1:0]        wrPar;
	logic [ECC_W-1:0]        wrEcc;
	logic [DATA_W-1:0]       rdData;
	logic [LANES-1:0]        rdPar;
	logic [ECC_W-1:0]        rdEccCalc;
	logic [DATA_W-1:0]       oldData;
	logic [DATA_W-1:0]       merged;
	logic                    chkErr;
	logic                    reEcc;
	logic                    reZero;
	logic                    reOne;
	logic                    reHs;
	logic                    weEcc;
	logic                    weZero;
	logic                    weOne;
	logic                    weHs;

	// ****************************************************************
	// address decode
	// ****************************************************************
	// ranges are fixed; a depth parameter smaller than its range aliases
	always_comb begin
		decBank = BK_NONE;
		if (busReq.addr >= ECC_BASE && busReq.addr <= ECC_LAST) begin
			decBank = BK_ECC;
		end else if (busReq.addr >= ZERO_BASE && busReq.addr <= ZERO_LAST) begin
			decBank = BK_ZERO;
		end else if (busReq.addr >= ONE_BASE && busReq.addr <= ONE_LAST) begin
			decBank = BK_ONE;
		end else if (busReq.addr >= HS_BASE && busReq.addr <= HS_LAST) begin
			decBank = BK_HS;
		end
	end

	// the merge cycle re-addresses the word that the idle cycle took
	assign addrSel = (r.st == ST_IDLE) ? busReq.addr : r.addr;
	assign bankSel = (r.st == ST_IDLE) ? decBank : r.bank;
	assign offEcc  = addrSel - ECC_BASE;
	assign offZero = addrSel - ZERO_BASE;
	assign offOne  = addrSel - ONE_BASE;
	assign offHs   = addrSel - HS_BASE;

	// ****************************************************************
	// check-bit generation
	// ****************************************************************
	// only aligned word index used, no boundary split
	always_comb begin
		case (r.bank)
			BK_ECC:  oldData = rdEcc[DATA_W-1:0];
			BK_ZERO: oldData = rdZero[DATA_W-1:0];
			BK_ONE:  oldData = rdOne[DATA_W-1:0];
			default: oldData = rdHs[DATA_W-1:0];
		endcase
		for (int l = 0; l < LANES; l++) begin
			merged[8*l +: 8] = r.be[l] ? r.wdata[8*l +: 8] : oldData[8*l +: 8];
		end
	end

	assign rdData = oldData;
	assign wrData = (r.st == ST_MERGE) ? merged : busReq.wdata;
	assign memBe  = (r.st == ST_MERGE) ? BE_FULL : busReq.be;

	orpea_codec uWrCodec (
		.data (wrData),
		.par  (wrPar),
		.ecc  (wrEcc)
	);

	orpea_codec uRdCodec (
		.data (rdData),
		.par  (rdPar),
		.ecc  (rdEccCalc)
	);

	// recomputed check bits against stored ones; any difference is an error
	always_comb begin
		case (r.bank)
			BK_ECC:  chkErr = (rdEccCalc != rdEcc[ECC_LSB +: ECC_W]);
			BK_ZERO: chkErr = (rdPar != rdZero[PAR_LSB +: LANES]);
			BK_ONE:  chkErr = (rdPar != rdOne[PAR_LSB +: LANES]);
			default: chkErr = (rdPar != rdHs[PAR_LSB +: LANES]);
		endcase
	end

	// ****************************************************************
	// arrays
	// ****************************************************************
	// only the addressed bank is enabled, which keeps idle banks quiet
	assign reEcc  = memRe && (bankSel == BK_ECC);
	assign reZero = memRe && (bankSel == BK_ZERO);
	assign reOne  = memRe && (bankSel == BK_ONE);
	assign reHs   = memRe && (bankSel == BK_HS);
	assign weEcc  = memWe && (bankSel == BK_ECC);
	assign weZero = memWe && (bankSel == BK_ZERO);
	assign weOne  = memWe && (bankSel == BK_ONE);
	assign weHs   = memWe && (bankSel == BK_HS);

	// ecc bank: whole words only, so each bank keeps a process of its own
	// and maps onto a separate ram macro
	always_ff @(posedge ref_clk) begin
		if (reEcc) begin
			rdEcc <= ramEcc[offEcc[ECC_IW+1:2]];
		end
		// ecc stored with word
		// a partial write only lands here from the merge cycle
		if (weEcc) begin
			ramEcc[offEcc[ECC_IW+1:2]] <= {wrEcc, wrData};
		end
	end

	// parity bank zero: each enabled lane keeps its own parity bit
	always_ff @(posedge ref_clk) begin
		if (reZero) begin
			rdZero <= ramZero[offZero[ZERO_IW+1:2]];
		end
		for (int l = 0; l < LANES; l++) begin
			if (weZero && memBe[l]) begin
				ramZero[offZero[ZERO_IW+1:2]][8*l +: 8]  <= wrData[8*l +: 8];
				ramZero[offZero[ZERO_IW+1:2]][PAR_LSB+l] <= wrPar[l];
			end
		end
	end

	// parity bank one: same lane layout as bank zero
	always_ff @(posedge ref_clk) begin
		if (reOne) begin
			rdOne <= ramOne[offOne[ONE_IW+1:2]];
		end
		for (int l = 0; l < LANES; l++) begin
			if (weOne && memBe[l]) begin
				ramOne[offOne[ONE_IW+1:2]][8*l +: 8]  <= wrData[8*l +: 8];
				ramOne[offOne[ONE_IW+1:2]][PAR_LSB+l] <= wrPar[l];
			end
		end
	end

	// high-speed bank: parity like the others, but read without a wait cycle
	always_ff @(posedge ref_clk) begin
		if (reHs) begin
			rdHs <= ramHs[offHs[HS_IW+1:2]];
		end
		for (int l = 0; l < LANES; l++) begin
			if (weHs && memBe[l]) begin
				ramHs[offHs[HS_IW+1:2]][8*l +: 8]  <= wrData[8*l +: 8];
				ramHs[offHs[HS_IW+1:2]][PAR_LSB+l] <= wrPar[l];
			end
		end
	end

	// ****************************************************************
	// access sequencer
	// ****************************************************************
	// reads answer one or two cycles after the read edge; writes answer
	// at once except a partial ecc write, which needs a read-modify-write
	always_comb begin
		next_r = r;
		next_r.rsp.valid = 1'b0;
		next_r.rsp.err = 1'b0;
		next_r.errEvent = 1'b0;
		memRe = 1'b0;
		memWe = 1'b0;
		next_r.waitOn = ~zeroWaitSel;
		case (r.st)
			ST_IDLE: begin
				if (busReq.valid && r.ready) begin
					next_r.addr = busReq.addr;
					next_r.wdata = busReq.wdata;
					next_r.be = busReq.be;
					next_r.bank = decBank;
					if (decBank == BK_NONE) begin
						next_r.rsp.valid = 1'b1;
						next_r.rsp.err = 1'b1;
						next_r.rsp.rdata = '0;
					end else if (busReq.write) begin
						if (decBank == BK_ECC && busReq.be != BE_FULL) begin
							// partial word: fetch old data first
							memRe = 1'b1;
							next_r.st = ST_MERGE;
						end else begin
							memWe = 1'b1;
							next_r.rsp.valid = 1'b1;
							next_r.rsp.rdata = '0;
						end
					end else begin
						memRe = 1'b1;
						if (decBank == BK_HS || !r.waitOn) begin
							next_r.st = ST_CHECK;
						end else begin
							next_r.st = ST_WAIT;
						end
					end
				end
			end
			ST_WAIT: begin
				next_r.st = ST_CHECK;
			end
			ST_CHECK: begin
				next_r.rsp.valid = 1'b1;
				next_r.rsp.rdata = rdData;
				next_r.rsp.err = chkErr;
				next_r.errEvent = chkErr;
				next_r.st = ST_IDLE;
			end
			ST_MERGE: begin
				memWe = 1'b1;
				next_r.rsp.valid = 1'b1;
				next_r.rsp.rdata = '0;
				next_r.st = ST_IDLE;
			end
			default: begin
				next_r.st = ST_IDLE;
			end
		endcase
		// no access held in deep standby
		next_r.ready = (next_r.st == ST_IDLE) && !moduleStop && !deepStandby;
	end

	// an access in flight completes before stop takes effect
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			r <= '0;
			r.waitOn <= WAIT_RST;
		end else begin
			r <= next_r;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign busReady = r.ready;
	assign busRsp   = r.rsp;
	assign errEvent = r.errEvent;

endmodule

// ---- pkg/orpea_pkg.sv ----
// Overview of operation
// - lowest 32 KB of bank zero uses ECC
// - other RAM: even parity bit per byte
// - ECC area: no parity, detects 2-bit errors
// - read wait state inserted after reset
// - wait state removable at or below 60 MHz
// - high-speed bank always zero wait
// - bank zero parity and bank one ranges
// - high-speed bank 128 KB below bank zero
// - module-stop halts RAM operation
// - contents lost across deep standby; the arrays here keep them, deepStandby only drops ready
package orpea_pkg;

	// ****************************************************************
	// address map
	// ****************************************************************
	localparam logic [31:0] ECC_BASE  = 32'h2000_0000;
	localparam logic [31:0] ECC_LAST  = 32'h2000_7fff;
	localparam logic [31:0] ZERO_BASE = 32'h2000_8000;
	localparam logic [31:0] ZERO_LAST = 32'h2003_ffff;
	localparam logic [31:0] ONE_BASE  = 32'h2004_0000;
	localparam logic [31:0] ONE_LAST  = 32'h2007_ffff;
	localparam logic [31:0] HS_BASE   = 32'h1ffe_0000;
	localparam logic [31:0] HS_LAST   = 32'h1fff_ffff;

	// bank sizes in 32-bit words
	localparam int ECC_WORDS  = 32'h0000_2000;
	localparam int ZERO_WORDS = 32'h0000_e000;
	localparam int ONE_WORDS  = 32'h0001_0000;
	localparam int HS_WORDS   = 32'h0000_8000;

	// ****************************************************************
	// word layout
	// ****************************************************************
	localparam int DATA_W   = 32'h0000_0020;
	localparam int LANES    = 32'h0000_0004;
	localparam int HAM_W    = 32'h0000_0006;
	localparam int ECC_W    = 32'h0000_0007;
	localparam int CODE_POS = 32'h0000_0026;
	localparam int PAR_LSB  = 32'h0000_0020;
	localparam int ECC_LSB  = 32'h0000_0020;

	// reset value and full byte-enable mask
	localparam logic WAIT_RST  = 1'b1;
	localparam logic [3:0] BE_FULL = 4'hf;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_CHECK,
		ST_MERGE
	} orpea_state_t;

	typedef enum logic [2:0] {
		BK_NONE,
		BK_ECC,
		BK_ZERO,
		BK_ONE,
		BK_HS
	} orpea_bank_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} orpea_req_t;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [31:0] rdata;
	} orpea_rsp_t;

	typedef struct packed {
		orpea_state_t st;
		orpea_bank_t  bank;
		logic         waitOn;
		logic         ready;
		logic [31:0]  addr;
		logic [31:0]  wdata;
		logic [3:0]   be;
		orpea_rsp_t   rsp;
		logic         errEvent;
	} orpea_ctl_t;

endpackage

// ---- rtl/orpea_codec.sv ----
`timescale 1ns/1ns
// check-bit generator: byte parity plus secded code over one word
module orpea_codec (
	input  wire logic [orpea_pkg::DATA_W-1:0] data,
	output logic      [orpea_pkg::LANES-1:0]  par,
	output logic      [orpea_pkg::ECC_W-1:0]  ecc
);
	import orpea_pkg::*;

	logic [HAM_W-1:0] ham;

	// ****************************************************************
	// even parity per byte
	// ****************************************************************
	// byte even parity
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : gLane
			assign par[g] = ^data[8*g +: 8];
		end
	endgenerate

	// ****************************************************************
	// hamming code plus overall parity
	// ****************************************************************
	// data bits sit at the non power-of-two code positions; the extra overall
	// bit turns single correction into a guaranteed double detection
	// double error detection
	always_comb begin
		int k;
		k = 0;
		ham = '0;
		for (int p = 1; p <= CODE_POS; p++) begin
			if ((p & (p - 1)) != 0) begin
				for (int i = 0; i < HAM_W; i++) begin
					if (p[i]) begin
						ham[i] = ham[i] ^ data[k];
					end
				end
				k = k + 1;
			end
		end
		ecc = {(^data) ^ (^ham), ham};
	end

endmodule

// ---- verification/orpea_ram_props.sv ----
`timescale 1ns/1ns
// ****
// response timing checks
// ****
module orpea_ram_props #(
	parameter int ECC_DEPTH  = orpea_pkg::ECC_WORDS,
	parameter int ZERO_DEPTH = orpea_pkg::ZERO_WORDS,
	parameter int ONE_DEPTH  = orpea_pkg::ONE_WORDS,
	parameter int HS_DEPTH   = orpea_pkg::HS_WORDS
) (
	input wire logic                  ref_clk,
	input wire logic                  rstn,
	input wire orpea_pkg::orpea_req_t busReq,
	input wire logic                  busReady,
	input wire orpea_pkg::orpea_rsp_t busRsp,
	input wire logic                  zeroWaitSel,
	input wire logic                  moduleStop,
	input wire logic                  deepStandby,
	input wire logic                  errEvent
);
	import orpea_pkg::*;
	logic ecc;
	logic par;
	logic hs;
	// decode of the request address; bank zero and one are contiguous
	assign ecc = busReq.addr >= ECC_BASE && busReq.addr <= ECC_LAST;
	assign par = busReq.addr >= ZERO_BASE && busReq.addr <= ONE_LAST;
	assign hs = busReq.addr >= HS_BASE && busReq.addr <= HS_LAST;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence s_take; busReq.valid && busReady; endsequence
	sequence s_rd; s_take ##0 !busReq.write; endsequence
	sequence s_gap1; !busRsp.valid ##1 busRsp.valid; endsequence
	property p_rstQuiet;
		disable iff (1'b0) !rstn |=> !busReady && !busRsp.valid && !errEvent;
	endproperty
	property p_write;
		s_take ##0 busReq.write && (busReq.be == BE_FULL || !ecc) |=> busRsp.valid;
	endproperty
	property p_eccRmw;
		s_take ##0 busReq.write && busReq.be != BE_FULL && ecc |=> s_gap1;
	endproperty
	property p_waitRead;
		s_rd ##0 (ecc || par) && !zeroWaitSel && !$past(zeroWaitSel) |=> !busRsp.valid ##1 s_gap1;
	endproperty
	property p_zeroRead;
		s_rd ##0 (ecc || par) && zeroWaitSel && $past(zeroWaitSel) |=> s_gap1;
	endproperty
	property p_hsRead;
		s_rd ##0 hs |=> s_gap1;
	endproperty
	property p_unmapped;
		s_take ##0 !(ecc || par || hs) |=> busRsp.valid && busRsp.err && !errEvent;
	endproperty
	property p_stop;
		(moduleStop || deepStandby) [*6] |-> !busReady && !busRsp.valid;
	endproperty
	property p_errEvent;
		errEvent |-> busRsp.valid && busRsp.err;
	endproperty
	a_rstQuiet: assert property (p_rstQuiet) else $error("busy in reset");
	a_write: assert property (p_write) else $error("write answer late");
	a_eccRmw: assert property (p_eccRmw) else $error("merge answer");
	a_waitRead: assert property (p_waitRead) else $error("wait read");
	a_zeroRead: assert property (p_zeroRead) else $error("zero read");
	a_hsRead: assert property (p_hsRead) else $error("fast read");
	a_unmapped: assert property (p_unmapped) else $error("decode");
	a_stop: assert property (p_stop) else $error("stop ignored");
	a_errEvent: assert property (p_errEvent) else $error("stray event");
endmodule
bind orpea_ram_ctrl orpea_ram_props #(
	.ECC_DEPTH(ECC_DEPTH), .ZERO_DEPTH(ZERO_DEPTH), .ONE_DEPTH(ONE_DEPTH), .HS_DEPTH(HS_DEPTH)
) orpea_ram_props_inst (
	.ref_clk(ref_clk), .rstn(rstn), .busReq(busReq), .busReady(busReady), .busRsp(busRsp),
	.zeroWaitSel(zeroWaitSel), .moduleStop(moduleStop), .deepStandby(deepStandby),
	.errEvent(errEvent)
);

// ---- verification/orpea_bus_master.sv ----
`timescale 1ns/1ns
// ****
// bus master model
// ****
module orpea_bus_master (
	input  wire logic             ref_clk,
	input  wire logic             busReady,
	output orpea_pkg::orpea_req_t busReq
);
	import orpea_pkg::*;
	int stuck;
	initial begin
		busReq = '0;
		stuck = 0;
	end
	// one transfer, held until an edge samples ready high
	task automatic xfer(input logic w, input logic [31:0] a, d, input logic [3:0] be);
		int t;
		@(negedge ref_clk);
		busReq <= '{valid: 1'b1, write: w, addr: {a[31:2], 2'b00}, wdata: d, be: be};
		t = 0;
		do begin
			@(posedge ref_clk);
			t++;
		end while (busReady !== 1'b1 && t < 200);
		if (t >= 200) stuck++;
		@(negedge ref_clk);
		// released lines show the inverse, never a stale copy
		busReq <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d, be: ~be};
	endtask
endmodule

// ---- verification/test_onchip_ram_parity_ecc_access.sv ----
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errCount++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module test_onchip_ram_parity_ecc_access;
	import orpea_pkg::*;
	typedef struct packed {logic chk; logic err; logic [31:0] data;} orpea_note_t;
	logic        ref_clk, rstn, zeroWaitSel, moduleStop, deepStandby, busReady, errEvent;
	orpea_req_t  busReq;
	orpea_rsp_t  busRsp;
	int          errCount, checked, seed;
	orpea_note_t noteQ[$];
	logic [31:0] mem[logic [31:0]];
	// ****
	// clock and design
	// ****
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	orpea_ram_ctrl #(.ECC_DEPTH(16), .ZERO_DEPTH(16), .ONE_DEPTH(16), .HS_DEPTH(16))
	orpea_ram_ctrl_inst (.ref_clk(ref_clk), .rstn(rstn), .busReq(busReq),
		.busReady(busReady), .busRsp(busRsp), .zeroWaitSel(zeroWaitSel),
		.moduleStop(moduleStop), .deepStandby(deepStandby), .errEvent(errEvent));
	orpea_bus_master orpea_bus_master_inst (.ref_clk(ref_clk), .busReady(busReady),
		.busReq(busReq));
	// note the expectation, then hand the transfer to the master
	task automatic acc(input logic w, input logic [31:0] a, d, input logic [3:0] be);
		orpea_note_t n;
		logic        hit;
		hit = (a >= HS_BASE && a <= HS_LAST) || (a >= ECC_BASE && a <= ONE_LAST);
		n = '{chk: !w, err: !hit, data: 32'h0};
		if (hit && mem.exists(a)) n.data = mem[a];
		for (int i = 0; i < 4; i++) begin
			if (w && be[i]) n.data[8*i +: 8] = d[8*i +: 8];
		end
		if (w && hit) mem[a] = n.data;
		noteQ.push_back(n);
		orpea_bus_master_inst.xfer(w, a, d, be);
	endtask
	task automatic printVerdict;
		if (errCount == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// each answer takes the oldest note; early answers only work because order is kept
	always @(negedge ref_clk) begin
		orpea_note_t n;
		if (busRsp.valid === 1'b1) begin
			n = '{default: 1'bx};
			if (noteQ.size() != 0) n = noteQ.pop_front();
			`CHK(errEvent, 1'b0)
			`CHK(busRsp.err, n.err)
			if (n.chk) `CHK(busRsp.rdata, n.data)
		end
	end
	// watchdog, far beyond the expected several hundred cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		errCount++;
		printVerdict();
	end
	// ****
	// main sequence
	// ****
	initial begin
		logic [31:0] bases[4];
		logic [31:0] lasts[4];
		int          k;
		logic        w;
		errCount = 0;
		checked = 0;
		seed = 62;
		rstn = 1'b0;
		zeroWaitSel = 1'b0;
		moduleStop = 1'b0;
		deepStandby = 1'b0;
		bases = '{ECC_BASE, ZERO_BASE, ONE_BASE, HS_BASE};
		lasts = '{ECC_LAST, ZERO_LAST, ONE_LAST, HS_LAST};
		repeat (6) @(negedge ref_clk);
		rstn <= 1'b1;
		// both wait settings, every bank, boundary words and random mixes
		for (int z = 0; z < 2; z++) begin
			zeroWaitSel <= z[0];
			for (int b = 0; b < 4; b++) begin
				acc(1'b1, lasts[b] - 32'h3, $random(seed), BE_FULL);
				acc(1'b0, lasts[b] - 32'h3, 32'h0, BE_FULL);
				for (int i = 0; i < 15; i++) acc(1'b1, bases[b] + 4 * i, $random(seed), BE_FULL);
				repeat (12) begin
					k = $unsigned($random(seed)) % 15;
					w = 1'($random(seed));
					acc(w, bases[b] + 4 * k, $random(seed), 4'($random(seed)));
				end
			end
		end
		// just outside each end of the map
		acc(1'b0, HS_BASE - 32'h4, 32'h0, BE_FULL);
		acc(1'b1, ONE_LAST + 32'h1, 32'h0, BE_FULL);
		// stop and standby hold off a pending write until released
		for (int s = 0; s < 2; s++) begin
			if (s == 0) moduleStop <= 1'b1;
			else deepStandby <= 1'b1;
			fork
				acc(1'b1, HS_BASE, $random(seed), BE_FULL);
				begin
					repeat (8) @(negedge ref_clk);
					`CHK(busReady, 1'b0)
					moduleStop <= 1'b0;
					deepStandby <= 1'b0;
				end
			join
			acc(1'b0, HS_BASE, 32'h0, BE_FULL);
		end
		for (int t = 0; t < 50 && noteQ.size() != 0; t++) @(negedge ref_clk);
		`CHK(noteQ.size(), 0)
		`CHK(orpea_bus_master_inst.stuck, 0)
		printVerdict();
	end
endmodule
